//--- usb_port_mode_ctrl.sv
// mode control for a downstream usb charging port: attach, power, vconn, data switches
// assumes analog comparators deliver cc, supply and data-line levels as logic pins
//
// Summary of operation
// [RQ1] sample enable only after supply rises above undervoltage lockout
// [RQ2] enable high starts start-up; enable low keeps the port inactive
// [RQ3] after start-up, watch both cc lines for a sink
// [RQ4] regulator turns on only after the attach stays valid for the debounce time
// [RQ5] debounced attach turns on the load switch gate drive
// [RQ6] ra on the line opposite the sink gets vconn
// [RQ7] always start in type-c mode, then follow the mode-select pins
// [RQ8] cdp behaviour also responds to portable device data-line signalling
// [RQ9] client mode: regulator and load switch off, data switches on
// [RQ10] client chosen at start-up keeps data switches on whatever the line voltages
// [RQ11] data switches may turn on in cdp, sdp and client modes
// [RQ12] in client mode data switches turn on once enable is high
// [RQ13] in cdp or sdp, data switches stay off until rd is seen
// [RQ14] in cdp, data switches stay on through the charging handshake
// [RQ15] enable low forces data switches off
// [RQ16] data-line overvoltage forces switches off and raises a fault
// [RQ17] portable device drives dp and reads dm to tell sdp from cdp
// [RQ18] portable device drives dm and reads dp to tell cdp from dedicated port
// [RQ19] upstream host must be active for sdp or cdp charging; the code has no host input, so sdp and cdp power does not depend on it
// [RQ20] mode pins: 0x client off, 10 sdp, 11 cdp; power only for 1x
// [RQ21] keep watching mode pins; no data switch drop on mode change after rd
// [RQ22] cdp to client drops bus power; cdp to sdp keeps it on
// [RQ23] debounce length is a parameter in clock cycles
// [RQ24] detach returns to type-c watch with power, vconn and data switches off; client mode keeps data switches on
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module usb_port_mode_ctrl
  import port_ctl_pkg::*;
#(
  parameter int DEBOUNCE = DEBOUNCE_CYCLES
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RESET_N,
  input  wire logic              I_SUPPLY_ABOVE_UVLO,
  input  wire logic              I_ENABLE_UNDERVOLTAGE_INPUT,
  input  wire logic              I_MODE_SELECT_A,
  input  wire logic              I_MODE_SELECT_B,
  input  wire logic              I_CC1_RD_SEEN,
  input  wire logic              I_CC2_RD_SEEN,
  input  wire logic              I_CC1_RA_SEEN,
  input  wire logic              I_CC2_RA_SEEN,
  input  wire logic              I_DATA_OVERVOLTAGE,
  input  wire logic              I_PORT_DATA_PLUS_HIGH,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic                   O_REGULATOR_EN,
  output logic                   O_LOAD_SWITCH_GATE_DRIVE,
  output logic                   O_VCONN_CC1,
  output logic                   O_VCONN_CC2,
  output logic                   O_DATA_SWITCH_EN,
  output logic                   O_OVERVOLTAGE_FAULT,
  output logic                   O_PORT_DATA_MINUS_SOURCE,
  output logic [DATA_W-1:0]      O_RDATA
);

  logic [NUM_PINS-1:0] pins_in;
  logic [NUM_PINS-1:0] sync1_r;
  logic [NUM_PINS-1:0] sync2_r;
  logic uvlo_s;
  logic en_s;
  logic mode_a_s;
  logic mode_b_s;
  logic cc1_rd_s;
  logic cc2_rd_s;
  logic cc1_ra_s;
  logic cc2_ra_s;
  logic ovp_s;
  logic dp_high_s;
  state_t state_r;
  state_t state_nxt;
  logic client_start_r;
  logic rd_seen_r;
  logic fault_r;
  logic fault_clr;
  logic en_ok;
  logic client;
  logic cdp;
  logic client_lock;
  logic run;
  logic active;
  logic reg_nxt;
  logic vconn1_nxt;
  logic vconn2_nxt;
  logic dsw_nxt;
  logic dm_src_nxt;
  logic [DATA_W-1:0] status;
  attach_if att ();

  assign pins_in = {I_SUPPLY_ABOVE_UVLO, I_ENABLE_UNDERVOLTAGE_INPUT, I_MODE_SELECT_A,
                    I_MODE_SELECT_B, I_CC1_RD_SEEN, I_CC2_RD_SEEN, I_CC1_RA_SEEN,
                    I_CC2_RA_SEEN, I_DATA_OVERVOLTAGE, I_PORT_DATA_PLUS_HIGH};

  // two-stage synchronisers, one per pin; only stage two is read
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pins_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  assign {uvlo_s, en_s, mode_a_s, mode_b_s, cc1_rd_s, cc2_rd_s,
          cc1_ra_s, cc2_ra_s, ovp_s, dp_high_s} = sync2_r;

  // mode decode: a selects bus power, a with b selects cdp
  assign client      = ~mode_a_s;                          // [RQ20]
  assign cdp         = mode_a_s & mode_b_s;                // [RQ20]
  assign en_ok       = en_s & uvlo_s;
  assign client_lock = client_start_r & client;
  assign run         = (state_r == ST_TYPEC) || (state_r == ST_ACTIVE);
  assign active      = (state_r == ST_ACTIVE);

  assign att.run    = run;                                 // [RQ3]
  assign att.cc1_rd = cc1_rd_s;
  assign att.cc2_rd = cc2_rd_s;

  attach_debounce #(
    .CNT_W    (DEB_CNT_W),
    .DEBOUNCE (DEBOUNCE)
  ) u_attach (
    .clk   (I_CLK),
    .rst_n (I_RESET_N),
    .a     (att)
  );

  always_comb begin
    state_nxt = state_r;
    if (!uvlo_s) begin
      state_nxt = ST_OFF;
    end else begin
      case (state_r)
        ST_OFF: begin
          state_nxt = ST_SAMPLE;                           // [RQ1]
        end
        ST_SAMPLE: begin
          if (en_s) begin
            state_nxt = ST_STARTUP;                        // [RQ2]
          end
        end
        ST_STARTUP: begin
          state_nxt = en_s ? ST_TYPEC : ST_SAMPLE;         // [RQ7]
        end
        ST_TYPEC: begin
          if (!en_s) begin
            state_nxt = ST_SAMPLE;
          end else if (att.attached) begin
            state_nxt = ST_ACTIVE;                         // [RQ4]
          end
        end
        ST_ACTIVE: begin
          if (!en_s) begin
            state_nxt = ST_SAMPLE;
          end else if (!att.attached) begin
            state_nxt = ST_TYPEC;                          // [RQ24]
          end
        end
        default: begin
          state_nxt = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the mode seen during start-up decides whether client mode is pinned on
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      client_start_r <= 1'b0;
    end else if (state_r == ST_OFF || state_r == ST_SAMPLE) begin
      client_start_r <= 1'b0;
    end else if (state_r == ST_STARTUP) begin
      client_start_r <= client;                            // [RQ10]
    end
  end

  // rd memory lets data switches survive mode changes until detach
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rd_seen_r <= 1'b0;
    end else if (!run) begin
      rd_seen_r <= 1'b0;
    end else if (active && !att.attached) begin
      rd_seen_r <= 1'b0;                                   // [RQ24]
    end else if (cc1_rd_s || cc2_rd_s) begin
      rd_seen_r <= 1'b1;                                   // [RQ13] [RQ21]
    end else if (!active) begin
      rd_seen_r <= 1'b0;
    end
  end

  // power follows the mode pins live, so cdp to sdp never drops the bus
  assign reg_nxt    = active & mode_a_s;                   // [RQ9] [RQ20] [RQ22]
  assign vconn1_nxt = active & att.sink_cc2 & cc1_ra_s;    // [RQ6]
  assign vconn2_nxt = active & ~att.sink_cc2 & cc2_ra_s;   // [RQ6]

  // overvoltage is ignored only while client mode is pinned from start-up
  always_comb begin
    dsw_nxt = 1'b0;
    if (!en_ok) begin
      dsw_nxt = 1'b0;                                      // [RQ15]
    end else if (client_lock) begin
      dsw_nxt = 1'b1;                                      // [RQ10]
    end else if (ovp_s) begin
      dsw_nxt = 1'b0;                                      // [RQ16]
    end else if (client) begin
      dsw_nxt = 1'b1;                                      // [RQ12] [RQ11]
    end else begin
      dsw_nxt = rd_seen_r;                                 // [RQ13] [RQ11]
    end
  end

  // cdp answers the portable device's dp probe by sourcing on dm
  assign dm_src_nxt = active & cdp & O_DATA_SWITCH_EN & dp_high_s; // [RQ8] [RQ14]

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_REGULATOR_EN           <= 1'b0;
      O_LOAD_SWITCH_GATE_DRIVE <= 1'b0;
    end else begin
      O_REGULATOR_EN           <= reg_nxt;                 // [RQ4]
      O_LOAD_SWITCH_GATE_DRIVE <= reg_nxt;                 // [RQ5]
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_VCONN_CC1 <= 1'b0;
      O_VCONN_CC2 <= 1'b0;
    end else begin
      O_VCONN_CC1 <= vconn1_nxt;
      O_VCONN_CC2 <= vconn2_nxt;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_DATA_SWITCH_EN <= 1'b0;
    end else begin
      O_DATA_SWITCH_EN <= dsw_nxt;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PORT_DATA_MINUS_SOURCE <= 1'b0;
    end else begin
      O_PORT_DATA_MINUS_SOURCE <= dm_src_nxt;
    end
  end

  // sticky fault: a new overvoltage in the clear cycle wins
  assign fault_clr = I_WR && (I_ADDR == REG_CONTROL) && I_WDATA[CTRL_FAULT_CLR_BIT];

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      fault_r <= 1'b0;
    end else if (ovp_s) begin
      fault_r <= 1'b1;                                     // [RQ16]
    end else if (fault_clr) begin
      fault_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_OVERVOLTAGE_FAULT <= 1'b0;
    end else begin
      O_OVERVOLTAGE_FAULT <= ovp_s | (fault_r & ~fault_clr);
    end
  end

  always_comb begin
    status                                = '0;
    status[STAT_STATE_LSB +: 3]           = state_r;
    status[STAT_ATTACH_BIT]               = att.attached;
    status[STAT_CC2_BIT]                  = att.sink_cc2;
    status[STAT_FAULT_BIT]                = fault_r;
    status[STAT_DSW_BIT]                  = O_DATA_SWITCH_EN;
    status[STAT_REG_BIT]                  = O_REGULATOR_EN;
  end

  // read data stand for one cycle only; unmapped reads give zero
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RDATA <= RDATA_RESET;
    end else if (I_RD && I_ADDR == REG_STATUS) begin
      O_RDATA <= status;
    end else begin
      O_RDATA <= RDATA_RESET;
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESET_N);
  sequence boot_seq;
    state_r == ST_OFF && uvlo_s ##1 state_r == ST_SAMPLE && en_s && uvlo_s;
  endsequence
  sequence start_seq;
    state_r == ST_STARTUP && en_s && uvlo_s;
  endsequence
  sample_first_a: assert property ( // [RQ1]
    state_r == ST_OFF |=> state_r == ST_OFF || state_r == ST_SAMPLE)
    else $error("left off state without sampling enable");
  enable_start_a: assert property ( // [RQ2]
    boot_seq |=> start_seq or (state_r == ST_OFF))
    else $error("enable high did not start up");
  enable_hold_a: assert property ( // [RQ2]
    state_r == ST_SAMPLE && !en_s |=> state_r != ST_STARTUP && !O_REGULATOR_EN)
    else $error("device active with enable low");
  monitor_after_a: assert property ( // [RQ3] [RQ7]
    start_seq |=> state_r == ST_TYPEC && att.run)
    else $error("cc monitoring not started after start-up");
  debounce_gate_a: assert property ( // [RQ4]
    $rose(O_REGULATOR_EN) |-> $past(att.attached, 2) && $past(mode_a_s))
    else $error("regulator on without debounced attach");
  gate_pair_a: assert property ( // [RQ5]
    active && mode_a_s ##1 active |-> O_LOAD_SWITCH_GATE_DRIVE && O_REGULATOR_EN)
    else $error("gate drive missing after attach");
  vconn_side_a: assert property ( // [RQ6]
    O_VCONN_CC1 |-> !O_VCONN_CC2 && $past(att.sink_cc2) && $past(cc1_ra_s))
    else $error("vconn applied to wrong cc line");
  client_dark_a: assert property ( // [RQ9] [RQ20]
    client [*2] |-> !O_REGULATOR_EN && !O_LOAD_SWITCH_GATE_DRIVE)
    else $error("bus power on in client mode");
  client_on_a: assert property ( // [RQ12] [RQ10]
    en_ok && client && (client_lock || !ovp_s) |=> O_DATA_SWITCH_EN)
    else $error("client data switches not on");
  rd_gate_a: assert property ( // [RQ13]
    !client && !client_lock && !rd_seen_r |=> !O_DATA_SWITCH_EN)
    else $error("data switches on before rd");
  en_low_off_a: assert property ( // [RQ15]
    !en_s |=> !O_DATA_SWITCH_EN)
    else $error("data switches on with enable low");
  ovp_off_a: assert property ( // [RQ16]
    ovp_s && !client_lock |=> !O_DATA_SWITCH_EN && O_OVERVOLTAGE_FAULT)
    else $error("overvoltage did not open data switches");
  mode_keep_a: assert property ( // [RQ21] [RQ14]
    O_DATA_SWITCH_EN && rd_seen_r && en_ok && !ovp_s && active
      && $changed(mode_b_s) |=> O_DATA_SWITCH_EN)
    else $error("data switches dropped on mode change");
  cdp_sdp_a: assert property ( // [RQ22]
    active && cdp ##1 active && mode_a_s && !mode_b_s |=> O_REGULATOR_EN)
    else $error("bus power lost on cdp to sdp change");
  detach_off_a: assert property ( // [RQ24]
    active && !att.attached && en_s && uvlo_s |=> state_r == ST_TYPEC
      ##1 !O_REGULATOR_EN && !O_VCONN_CC1 && !O_VCONN_CC2)
    else $error("detach left power or vconn on");

endmodule : usb_port_mode_ctrl

//--- port_ctl_pkg.sv
// constants, types and register map for the usb port mode controller
// assumes a single 10 MHz clock domain
package port_ctl_pkg;

  localparam int CLK_HZ          = 10_000_000;
  localparam int DEBOUNCE_NS     = 150_000;
  // least time: round up to whole cycles
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int DEB_CNT_W       = 16;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h4;
  localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;

  localparam int CTRL_FAULT_CLR_BIT = 0;

  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_ATTACH_BIT = 3;
  localparam int STAT_CC2_BIT    = 4;
  localparam int STAT_FAULT_BIT  = 5;
  localparam int STAT_DSW_BIT    = 6;
  localparam int STAT_REG_BIT    = 7;

  localparam int NUM_PINS = 10;

  typedef enum logic [2:0] {
    ST_OFF     = 3'h0,
    ST_SAMPLE  = 3'h1,
    ST_STARTUP = 3'h2,
    ST_TYPEC   = 3'h3,
    ST_ACTIVE  = 3'h4
  } state_t;

endpackage : port_ctl_pkg

//--- attach_if.sv
// carries sink attach detection between the mode controller and the debouncer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface attach_if;
  logic run;
  logic cc1_rd;
  logic cc2_rd;
  logic attached;
  logic sink_cc2;

  modport det (input run, input cc1_rd, input cc2_rd, output attached, output sink_cc2);
  modport ctl (output run, output cc1_rd, output cc2_rd, input attached, input sink_cc2);
endinterface : attach_if

//--- attach_debounce.sv
// debounces the sink termination seen on either cc line
// assumes cc inputs are already synchronised to clk
`timescale 1ns/1ps
module attach_debounce
  import port_ctl_pkg::*;
#(
  parameter int CNT_W    = DEB_CNT_W,
  parameter int DEBOUNCE = DEBOUNCE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  attach_if.det     a
);

  logic             rd_any;
  logic [CNT_W-1:0] cnt_r;
  logic             attached_r;
  logic             sink_cc2_r;

  assign rd_any     = a.cc1_rd | a.cc2_rd;
  assign a.attached = attached_r;
  assign a.sink_cc2 = sink_cc2_r;

  // the count restarts whenever the raw level agrees with the filtered one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (!a.run || rd_any == attached_r) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      attached_r <= 1'b0;
    end else if (!a.run) begin
      attached_r <= 1'b0;
    end else if (rd_any != attached_r && cnt_r == CNT_W'(DEBOUNCE - 1)) begin // [RQ4] [RQ23]
      attached_r <= rd_any;
    end
  end

  // orientation is frozen at attach so vconn cannot hop between lines
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sink_cc2_r <= 1'b0;
    end else if (!attached_r) begin
      sink_cc2_r <= a.cc2_rd & ~a.cc1_rd;
    end
  end

endmodule : attach_debounce

//--- sink_dev_model.sv
// behavioural attached sink device and its cable, seen from the port
// assumes the bench changes its commands just after rising edges of i_clk
`timescale 1ns/1ps
module sink_dev_model (
  input  wire logic i_clk,
  input  wire logic i_attach,
  input  wire logic i_flip,
  input  wire logic i_cable,
  input  wire logic i_probe,
  input  wire logic i_dm_source,
  output logic      o_cc1_rd,
  output logic      o_cc2_rd,
  output logic      o_cc1_ra,
  output logic      o_cc2_ra,
  output logic      o_dp_high,
  output logic      o_saw_cdp
);
  // rd sits on the cc pin the plug faces, an active cable's ra on the other
  assign o_cc1_rd = i_attach & ~i_flip;
  assign o_cc2_rd = i_attach & i_flip;
  assign o_cc1_ra = i_attach & i_cable & i_flip;
  assign o_cc2_ra = i_attach & i_cable & ~i_flip;
  // first probe step: drive data plus, then judge the port from data minus
  assign o_dp_high = i_attach & i_probe;
  // the port never drives data plus, so the second step reads low and confirms cdp
  always_ff @(posedge i_clk) begin
    o_saw_cdp <= o_dp_high & i_dm_source;
  end
endmodule : sink_dev_model

//--- tb_top.sv
// self-checking bench for the usb port mode controller against a sink model
// assumes 10 MHz clock and a debounce shortened to 4 cycles
`timescale 1ns/1ps
module tb_top;
  import port_ctl_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic       flip;
    logic       cab;
    logic       reg_on;
    logic       dsw_pre;
    logic [1:0] vc;
  } row_t;
  row_t rows [6] = '{'{2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0},
                     '{2'h1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0},
                     '{2'h2, 1'b0, 1'b1, 1'b1, 1'b0, 2'h1},
                     '{2'h2, 1'b1, 1'b1, 1'b1, 1'b0, 2'h2},
                     '{2'h3, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0},
                     '{2'h3, 1'b1, 1'b1, 1'b1, 1'b0, 2'h2}};
  logic       clk    = 1'b0;
  logic       rst_n  = 1'b0;
  logic       uvlo   = 1'b0;
  logic       en     = 1'b0;
  logic [1:0] mode   = 2'h0;
  logic       ov     = 1'b0;
  logic       attach = 1'b0;
  logic       flip   = 1'b0;
  logic       cab    = 1'b0;
  logic       probe  = 1'b0;
  logic [3:0] addr   = 4'h0;
  logic [7:0] wdata  = 8'h00;
  logic       wr     = 1'b0;
  logic       rd     = 1'b0;
  logic [7:0] rdata;
  logic [7:0] sv;
  logic       cc1_rd, cc2_rd, cc1_ra, cc2_ra, dp_high, saw_cdp;
  logic       reg_en, gate, vc1, vc2, dsw, fault, dm_src;
  int         err_count = 0;
  int         compares  = 0;

  always #50 clk = ~clk;

  usb_port_mode_ctrl #(.DEBOUNCE(4)) usb_port_mode_ctrl_inst (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_SUPPLY_ABOVE_UVLO(uvlo),
    .I_ENABLE_UNDERVOLTAGE_INPUT(en), .I_MODE_SELECT_A(mode[1]),
    .I_MODE_SELECT_B(mode[0]), .I_CC1_RD_SEEN(cc1_rd), .I_CC2_RD_SEEN(cc2_rd),
    .I_CC1_RA_SEEN(cc1_ra), .I_CC2_RA_SEEN(cc2_ra), .I_DATA_OVERVOLTAGE(ov),
    .I_PORT_DATA_PLUS_HIGH(dp_high), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_REGULATOR_EN(reg_en), .O_LOAD_SWITCH_GATE_DRIVE(gate),
    .O_VCONN_CC1(vc1), .O_VCONN_CC2(vc2), .O_DATA_SWITCH_EN(dsw),
    .O_OVERVOLTAGE_FAULT(fault), .O_PORT_DATA_MINUS_SOURCE(dm_src), .O_RDATA(rdata));

  sink_dev_model sink_dev_model_inst (
    .i_clk(clk), .i_attach(attach), .i_flip(flip), .i_cable(cab), .i_probe(probe),
    .i_dm_source(dm_src), .o_cc1_rd(cc1_rd), .o_cc2_rd(cc2_rd), .o_cc1_ra(cc1_ra),
    .o_cc2_ra(cc2_ra), .o_dp_high(dp_high), .o_saw_cdp(saw_cdp));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // ends 1 ns after an edge so checks see settled outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk) addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg

  task automatic up(input logic [1:0] m, input logic e, input logic s);
    @(posedge clk) rst_n <= 1'b0;
    {uvlo, en, ov, attach, probe} <= 5'h00;
    mode <= m;
    cyc(8);
    @(posedge clk) rst_n <= 1'b1;
    uvlo <= s;
    en <= e;
    cyc(10);
  endtask : up

  task automatic end_sim();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // whole run is under 1500 cycles; allow several times that
  initial begin
    #700_000;
    err_count++;
    end_sim();
  end

  initial begin
    foreach (rows[k]) begin
      up(rows[k].mode, 1'b1, 1'b1);
      @(posedge clk) flip <= rows[k].flip;
      cab <= rows[k].cab;
      cyc(1);
      chk("dsw before attach", 8'(rows[k].dsw_pre), 8'(dsw));
      chk("reg before attach", 8'h00, 8'(reg_en));
      @(posedge clk) attach <= 1'b1;
      cyc(14);
      chk("regulator", 8'(rows[k].reg_on), 8'(reg_en));
      chk("gate drive", 8'(rows[k].reg_on), 8'(gate));
      chk("dsw attached", 8'h01, 8'(dsw));
      chk("vconn", 8'(rows[k].vc), 8'({vc1, vc2}));
      @(posedge clk) attach <= 1'b0;
      cyc(14);
      chk("detach", 8'(rows[k].dsw_pre), 8'({reg_en, gate, vc1, vc2, dsw}));
    end
    up(2'h2, 1'b1, 1'b0);
    chk("reset outputs", 8'h00, 8'({reg_en, gate, vc1, vc2, dsw, fault, dm_src}));
    rd_reg(REG_STATUS, sv);
    chk("status no uvlo", 8'h00, sv);
    @(posedge clk) uvlo <= 1'b1;
    en <= 1'b0;
    flip <= 1'b0;
    attach <= 1'b1;
    cyc(14);
    rd_reg(REG_STATUS, sv);
    chk("status sample", 8'h01, sv);
    chk("inactive", 8'h00, 8'({reg_en, dsw}));
    @(posedge clk) attach <= 1'b0;
    en <= 1'b1;
    cyc(14);
    rd_reg(REG_STATUS, sv);
    chk("status typec", 8'h03, sv);
    @(posedge clk) attach <= 1'b1;
    cyc(14);
    rd_reg(REG_STATUS, sv);
    chk("status active", 8'hCC, sv);
    cyc(1);
    chk("rdata one cycle", 8'h00, rdata);
    rd_reg(4'hC, sv);
    chk("unmapped read", 8'h00, sv);
    @(posedge clk) en <= 1'b0;
    cyc(6);
    chk("dsw enable low", 8'h00, 8'(dsw));
    up(2'h3, 1'b1, 1'b1);
    @(posedge clk) attach <= 1'b1;
    // rd stands three cycles, one short of the debounce, so power must never rise
    cyc(2);
    @(posedge clk) attach <= 1'b0;
    repeat (14) begin
      cyc(1);
      chk("short rd ignored", 8'h00, 8'(reg_en));
    end
    @(posedge clk) attach <= 1'b1;
    cyc(14);
    @(posedge clk) probe <= 1'b1;
    cyc(8);
    chk("dm source cdp", 8'h01, 8'(dm_src));
    chk("sink saw cdp", 8'h01, 8'(saw_cdp));
    chk("dsw handshake", 8'h01, 8'(dsw));
    @(posedge clk) mode <= 2'h2;
    repeat (10) begin
      cyc(1);
      chk("cdp to sdp", 8'h03, 8'({reg_en, dsw}));
    end
    chk("dm source sdp", 8'h00, 8'(dm_src));
    @(posedge clk) mode <= 2'h0;
    cyc(8);
    chk("to client", 8'h01, 8'({reg_en, gate, dsw}));
    @(posedge clk) mode <= 2'h2;
    cyc(8);
    @(posedge clk) ov <= 1'b1;
    cyc(6);
    chk("ov dsw fault", 8'h01, 8'({dsw, fault}));
    rd_reg(REG_STATUS, sv);
    chk("status fault", 8'h01, 8'(sv[STAT_FAULT_BIT]));
    @(posedge clk) ov <= 1'b0;
    cyc(6);
    wr_reg(REG_CONTROL, 8'h01);
    cyc(2);
    chk("fault cleared", 8'h00, 8'(fault));
    up(2'h0, 1'b1, 1'b1);
    @(posedge clk) ov <= 1'b1;
    cyc(6);
    chk("client startup ov", 8'h03, 8'({dsw, fault}));
    end_sim();
  end
endmodule : tb_top
